/* File: logic/srp_pkg.sv */
// Shared constants and types for the serial register port
package srp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 24;
  // Bit counter landmarks within a frame
  localparam logic [4:0] BIT_DIR = 5'h00;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h0F;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h10;
  localparam logic [4:0] BIT_DATA_LAST = 5'h17;
  // Register offsets
  localparam logic [14:0] OFS_CONFIG_A = 15'h0000;
  localparam logic [14:0] OFS_POWER_CFG = 15'h0002;
  localparam logic [14:0] OFS_CLASS = 15'h0003;
  localparam logic [14:0] OFS_PART_LO = 15'h0004;
  localparam logic [14:0] OFS_PART_HI = 15'h0005;
  // Field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int ADDR_STEP_UP_BIT = 5;
  localparam int FIXED_ONE_BIT = 4;
  // Values after reset
  localparam logic [7:0] CONFIG_A_RST = 8'h30;
  localparam logic [7:0] POWER_CFG_RST = 8'h00;
  localparam logic [3:0] CLASS_HI_RST = 4'h0;
  // Power mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REDUCED = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_TIME_NS = 5;
  localparam int RESET_WAIT_RAW = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_WAIT_CYC = (RESET_WAIT_RAW < 1) ? 1 : RESET_WAIT_RAW;
  localparam int SCLK_HALF_CYC = 8;
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} srp_host_state_e;
endpackage

/* File: logic/srp_if.sv */
// Four-wire link between the host and the device end of the serial register port
interface srp_if;
  logic sclk;
  logic select_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic serial_out_line;

  // Undriven line reads low here; no pull-up is modelled
  assign serial_out_line = serial_out_oe_n ? 1'b0 : serial_out;

  modport host (
    output sclk,
    output select_n,
    output serial_in,
    input serial_out_line
  );

  modport device (
    input sclk,
    input select_n,
    input serial_in,
    output serial_out,
    output serial_out_oe_n
  );
endinterface

/* File: logic/srp_device.sv */
// Device end of the serial register port: frame decoder on sclk, registers on clk
module srp_device
  import srp_pkg::*;
#(
  parameter logic [3:0] CLASS_CODE = 4'hA, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic sys_rst,
  srp_if.device link,
  output logic [1:0] power_mode_q,
  output logic sleep_q,
  output logic power_down_q,
  output logic chip_reset_q
);

  // Link domain
  logic [4:0] bit_cnt_q;
  logic dir_rd_q;
  logic [13:0] addr_sh_q;
  logic [14:0] addr_q;
  logic [6:0] data_sh_q;
  logic [14:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_tgl_q;
  logic [19:0] pub_s1_q;
  logic [19:0] pub_s2_q;
  logic [7:0] rd_byte;
  logic [7:0] out_sh_q;
  logic out_oe_n_q;
  logic step_up;
  logic byte_done;

  // Clock domain
  logic rst_q;
  logic [2:0] wr_sync_q;
  logic wr_evt;
  logic soft_hit;
  logic [7:0] cfg_a_q;
  logic [7:0] pwr_q;
  logic [3:0] cls_hi_q;

  assign step_up = pub_s2_q[ADDR_STEP_UP_BIT];
  assign byte_done = (bit_cnt_q == BIT_DATA_LAST);

  // Select high clears the frame; sclk may stop anywhere, nothing times out
  always_ff @(posedge link.sclk or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      bit_cnt_q <= BIT_DIR;
    end
    else if (byte_done)
    begin
      bit_cnt_q <= BIT_DATA_FIRST;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge link.sclk or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      dir_rd_q <= 1'b0;
      addr_sh_q <= 14'h0000;
    end
    else
    begin
      if (bit_cnt_q == BIT_DIR)
      begin
        dir_rd_q <= link.serial_in;
      end
      if (bit_cnt_q < BIT_ADDR_LAST)
      begin
        addr_sh_q <= {addr_sh_q[12:0], link.serial_in};
      end
    end
  end

  always_ff @(posedge link.sclk or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      addr_q <= 15'h0000;
    end
    else if (bit_cnt_q == BIT_ADDR_LAST)
    begin
      addr_q <= {addr_sh_q, link.serial_in};
    end
    else if (byte_done)
    begin
      addr_q <= step_up ? addr_q + 15'h0001 : addr_q - 15'h0001;
    end
  end

  // Partial bytes never reach the holding registers
  always_ff @(posedge link.sclk or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      data_sh_q <= 7'h00;
    end
    else
    begin
      data_sh_q <= {data_sh_q[5:0], link.serial_in};
    end
  end

  // Held stable for a whole byte time, long enough for clk to pick up
  always_ff @(posedge link.sclk)
  begin
    if (!link.select_n && byte_done && !dir_rd_q)
    begin
      wr_addr_q <= addr_q;
      wr_data_q <= {data_sh_q, link.serial_in};
    end
  end

  always_ff @(posedge link.sclk or posedge rst_q)
  begin
    if (rst_q)
    begin
      wr_tgl_q <= 1'b0;
    end
    else if (!link.select_n && byte_done && !dir_rd_q)
    begin
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  // Quasi-static register bits; a read right after a write may see the old value
  always_ff @(posedge link.sclk)
  begin
    pub_s1_q <= {cls_hi_q, pwr_q, cfg_a_q};
    pub_s2_q <= pub_s1_q;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (addr_q == OFS_CONFIG_A)
    begin
      rd_byte = {1'b0, pub_s2_q[6:5], 1'b1, pub_s2_q[3:0]};
    end
    else if (addr_q == OFS_POWER_CFG)
    begin
      rd_byte = pub_s2_q[15:8];
    end
    else if (addr_q == OFS_CLASS)
    begin
      rd_byte = {pub_s2_q[19:16], CLASS_CODE};
    end
    else if (addr_q == OFS_PART_LO)
    begin
      rd_byte = PART_CODE[7:0];
    end
    else if (addr_q == OFS_PART_HI)
    begin
      rd_byte = PART_CODE[15:8];
    end
  end

  // Falling edge launch gives the host a full half period of setup
  always_ff @(negedge link.sclk or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      out_oe_n_q <= 1'b1;
      out_sh_q <= 8'h00;
    end
    else if (dir_rd_q && bit_cnt_q >= BIT_DATA_FIRST)
    begin
      out_oe_n_q <= 1'b0;
      if (bit_cnt_q == BIT_DATA_FIRST)
      begin
        out_sh_q <= rd_byte;
      end
      else
      begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
    else
    begin
      out_oe_n_q <= 1'b1;
    end
  end

  assign link.serial_out = out_sh_q[7];
  assign link.serial_out_oe_n = out_oe_n_q;

  always_ff @(posedge clk)
  begin
    rst_q <= sys_rst;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_sync_q <= 3'h0;
    end
    else
    begin
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
    end
  end

  assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
  assign soft_hit = wr_evt && (wr_addr_q == OFS_CONFIG_A) && wr_data_q[SOFT_RESET_BIT];

  // Unlisted addresses take no write
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_hit)
    begin
      cfg_a_q <= CONFIG_A_RST;
      pwr_q <= POWER_CFG_RST;
      cls_hi_q <= CLASS_HI_RST;
    end
    else if (wr_evt)
    begin
      if (wr_addr_q == OFS_CONFIG_A)
      begin
        cfg_a_q <= wr_data_q;
      end
      else if (wr_addr_q == OFS_POWER_CFG)
      begin
        pwr_q <= wr_data_q;
      end
      else if (wr_addr_q == OFS_CLASS)
      begin
        cls_hi_q <= wr_data_q[7:4];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      chip_reset_q <= 1'b0;
    end
    else
    begin
      chip_reset_q <= soft_hit;
    end
  end

  // Reduced-power code asserts neither sleep_q nor power_down_q, as normal; power_mode_q still shows it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      power_mode_q <= MODE_NORMAL;
      sleep_q <= 1'b0;
      power_down_q <= 1'b0;
    end
    else
    begin
      power_mode_q <= pwr_q[1:0];
      sleep_q <= (pwr_q[1:0] == MODE_SLEEP);
      power_down_q <= (pwr_q[1:0] == MODE_OFF);
    end
  end

endmodule

/* File: logic/srp_host.sv */
// Host end of the serial register port: sclk divider and frame sequencer
module srp_host
  import srp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int LEN_W = 8
)
(
  input wire logic clk,
  input wire logic sys_rst,
  srp_if.host link,
  input wire logic start,
  input wire logic read,
  input wire logic [14:0] addr,
  input wire logic [LEN_W-1:0] len,
  input wire logic [7:0] wdata,
  output logic busy_q,
  output logic wdata_take_q,
  output logic [7:0] rdata_q,
  output logic rdata_valid_q,
  output logic done_q
);

  localparam int PW = $clog2(2 * HALF_CYC);
  localparam logic [PW-1:0] PH_RISE = PW'(HALF_CYC - 1);
  localparam logic [PW-1:0] PH_LAST = PW'(2 * HALF_CYC - 1);
  localparam int GW = $clog2(RESET_WAIT_CYC + 1) + 1;
  localparam logic [GW-1:0] GAP_LAST = GW'(RESET_WAIT_CYC - 1);

  srp_host_state_e state_q;
  logic [PW-1:0] ph_q;
  logic [GW-1:0] gap_q;
  logic [4:0] bit_cnt_q;
  logic [LEN_W-1:0] left_q;
  logic rd_q;
  logic sclk_q;
  logic sel_n_q;
  logic [23:0] tx_q;
  logic [7:0] rx_q;
  logic [1:0] miso_s_q;
  logic bit_end;
  logic byte_end;
  logic frame_end;

  assign bit_end = (state_q == HS_SHIFT) && (ph_q == PH_LAST);
  assign byte_end = bit_end && (bit_cnt_q == BIT_DATA_LAST);
  assign frame_end = byte_end && (left_q == '0);

  assign link.sclk = sclk_q;
  assign link.select_n = sel_n_q;
  assign link.serial_in = tx_q[23];

  always_ff @(posedge clk)
  begin
    miso_s_q <= {miso_s_q[0], link.serial_out_line};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= HS_IDLE;
      ph_q <= '0;
      gap_q <= '0;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        HS_IDLE:
        begin
          if (start)
          begin
            state_q <= HS_SHIFT;
            ph_q <= '0;
            sel_n_q <= 1'b0;
          end
        end
        HS_SHIFT:
        begin
          ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
          if (ph_q == PH_RISE)
          begin
            sclk_q <= 1'b1;
          end
          if (bit_end)
          begin
            sclk_q <= 1'b0;
          end
          if (frame_end)
          begin
            state_q <= HS_GAP;
            sel_n_q <= 1'b1;
            gap_q <= '0;
          end
        end
        HS_GAP:
        begin
          // Select stays high long enough for a soft reset to finish
          gap_q <= gap_q + 1'b1;
          if (gap_q == GAP_LAST)
          begin
            state_q <= HS_IDLE;
          end
        end
        default:
        begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bit_cnt_q <= BIT_DIR;
      left_q <= '0;
      rd_q <= 1'b0;
      tx_q <= 24'h00_0000;
    end
    else if (state_q == HS_IDLE && start)
    begin
      bit_cnt_q <= BIT_DIR;
      left_q <= len;
      rd_q <= read;
      tx_q <= {read, addr, wdata};
    end
    else if (byte_end)
    begin
      bit_cnt_q <= BIT_DATA_FIRST;
      left_q <= left_q - 1'b1;
      tx_q <= {(frame_end || rd_q) ? 8'h00 : wdata, 16'h0000};
    end
    else if (bit_end)
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      tx_q <= {tx_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_q <= 8'h00;
    end
    else if (state_q == HS_SHIFT && ph_q == PH_RISE && bit_cnt_q >= BIT_DATA_FIRST)
    begin
      rx_q <= {rx_q[6:0], miso_s_q[1]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      wdata_take_q <= 1'b0;
      rdata_q <= 8'h00;
      rdata_valid_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_q != HS_IDLE) || start;
      wdata_take_q <= (state_q == HS_IDLE && start && !read)
                      || (byte_end && !frame_end && !rd_q);
      rdata_valid_q <= byte_end && rd_q;
      if (byte_end && rd_q)
      begin
        rdata_q <= rx_q;
      end
      done_q <= frame_end;
    end
  end

endmodule

/* File: test/srp_monitor.sv */
// Link protocol checker for the serial register port
module srp_monitor
  import srp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q;
  logic dir_q;
  logic [7:0] cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) sclk_q <= sclk;
  // Bits counted on clk, sclk is far slower
  always_ff @(posedge clk)
  begin
    if (sys_rst || select_n)
      cnt_q <= 8'h00;
    else if (sclk && !sclk_q)
      cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (!select_n && sclk && !sclk_q && cnt_q == 8'h00)
      dir_q <= serial_in;
  end
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_low;
    !sclk [*8];
  endsequence
  a_idle_release: assert property (select_n |-> serial_out_oe_n)
    else $error("output driven while deselected");
  a_idle_clock: assert property (select_n |-> !sclk)
    else $error("clock runs while deselected");
  a_quiet_bits: assert property (!select_n && (!dir_q || cnt_q < 8'h10) |->
    serial_out_oe_n) else $error("output driven outside read data");
  a_read_drive: assert property (!select_n && dir_q && cnt_q > 8'h10 &&
    cnt_q[2:0] != 3'h0 |-> !serial_out_oe_n) else $error("read data not driven");
  a_out_stable: assert property (!serial_out_oe_n && sclk |-> $stable(serial_out))
    else $error("read bit moved while clock high");
  a_in_stable: assert property (!select_n && sclk |-> $stable(serial_in))
    else $error("input bit moved while clock high");
  a_frame_whole: assert property ($rose(select_n) |->
    cnt_q >= 8'h18 && cnt_q[2:0] == 3'h0) else $error("frame not whole bytes");
  a_line_release: assert property ($rose(select_n) |-> !serial_out_line)
    else $error("data line not released after frame");
  a_gap_hold: assert property ($rose(select_n) |-> select_n [*2])
    else $error("deselect gap too short");
  a_high_phase: assert property ($rose(sclk) |-> s_high)
    else $error("clock high phase wrong");
  a_low_phase: assert property ($fell(sclk) |-> s_low)
    else $error("clock low phase short");
endmodule

/* File: test/testbench.sv */
// Bench joining host and device ends through the link
module testbench
  import srp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] CLS = 4'h6; // Arbitrary value
  localparam logic [15:0] PART = 16'h5A3C; // Arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic [14:0] addr = 15'h0000;
  logic [7:0] len = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic busy_q, rdata_valid_q, done_q, sleep_q, power_down_q, chip_reset_q;
  logic take_q;
  logic [7:0] rdata_q;
  logic [1:0] power_mode_q;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int pulses = 0;
  int takes = 0;
  logic [31:0] seed = 32'h0000_0054;
  logic [7:0] cfg = 8'h30;
  logic [7:0] pwr = 8'h00;
  srp_if link ();
  srp_host i_srp_host (.clk(clk), .sys_rst(sys_rst), .link(link.host), .start(start),
    .read(rd), .addr(addr), .len(len), .wdata(wdata), .busy_q(busy_q), .wdata_take_q(take_q),
    .rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q), .done_q(done_q));
  srp_device #(.CLASS_CODE(CLS), .PART_CODE(PART)) i_srp_device (.clk(clk),
    .sys_rst(sys_rst), .link(link.device), .power_mode_q(power_mode_q),
    .sleep_q(sleep_q), .power_down_q(power_down_q), .chip_reset_q(chip_reset_q));
  srp_monitor i_srp_monitor (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
    .select_n(link.select_n), .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe_n(link.serial_out_oe_n), .serial_out_line(link.serial_out_line));
  initial forever #5 clk = ~clk;
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the longest run
  always @(posedge clk)
  begin
    cyc++;
    if (chip_reset_q === 1'b1)
      pulses++;
    if (take_q === 1'b1)
      takes++;
    if (cyc == 50000)
    begin
      failures++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] expv(logic [14:0] a);
    case (a)
      15'h0000: return cfg;
      15'h0002: return pwr;
      15'h0003: return {4'h0, CLS};
      15'h0004: return PART[7:0];
      15'h0005: return PART[15:8];
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // One framed access; read bytes checked against the model as they land
  task automatic xfer(logic r, logic [14:0] a, int n, logic [7:0] w);
    int t;
    int k;
    logic [14:0] p;
    p = a;
    k = 0;
    for (t = 0; t < 100 && busy_q !== 1'b0; t++)
      step();
    takes = 0;
    start = 1'b1;
    rd = r;
    addr = a;
    len = 8'(n - 1);
    wdata = w;
    step();
    start = 1'b0;
    for (t = 0; t < 3000 && done_q !== 1'b1; t++)
    begin
      step();
      if (rdata_valid_q === 1'b1)
      begin
        chk(rdata_q, expv(p));
        p = cfg[5] ? p + 15'h0001 : p - 15'h0001;
        k++;
      end
    end
    chk({7'h00, done_q}, 8'h01);
    chk(8'(k), r ? 8'(n) : 8'h00);
    chk(8'(takes), r ? 8'h00 : 8'(n));
    // Model walks every written byte of a stream
    p = a;
    for (t = 0; t < n && !r; t++)
    begin
      if (p == 15'h0000)
        cfg = w[7] ? 8'h30 : {1'b0, w[6:5], 1'b1, w[3:0]};
      if (p == 15'h0000 && w[7])
        pwr = 8'h00;
      if (p == 15'h0002)
        pwr = w;
      p = cfg[5] ? p + 15'h0001 : p - 15'h0001;
    end
  endtask
  initial
  begin
    logic [14:0] a;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    xfer(1'b1, 15'h0000, 6, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b0, 15'h0002, 1, 8'(m));
      for (int t = 0; t < 20 && power_mode_q !== 2'(m); t++)
        step();
      chk({6'h00, power_mode_q}, 8'(m));
      chk({6'h00, sleep_q, power_down_q}, {6'h00, m == 2, m == 3});
      xfer(1'b1, 15'h0002, 1, 8'h00);
    end
    $display("test power modes done");
    xfer(1'b0, 15'h0004, 1, 8'h55);
    xfer(1'b0, 15'h0000, 1, 8'h10);
    xfer(1'b1, 15'h0005, 6, 8'h00);
    repeat (4)
    begin
      a = 15'(rnd() % 6);
      xfer(1'b1, a, 1 + int'(rnd() % 3), 8'h00);
    end
    $display("test streaming done");
    pulses = 0;
    xfer(1'b0, 15'h0000, 1, 8'h90);
    chk(8'(pulses), 8'h01);
    chk({6'h00, sleep_q, power_down_q}, 8'h00);
    xfer(1'b1, 15'h0000, 3, 8'h00);
    // Stream write over power and class registers, reserved nibble kept at zero
    xfer(1'b0, 15'h0002, 2, 8'h02);
    chk({6'h00, sleep_q, power_down_q}, 8'h02);
    xfer(1'b1, 15'h0002, 2, 8'h00);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
